// file: src/ocst_defines.svh
`ifndef OCST_DEFINES_SVH
`define OCST_DEFINES_SVH

// timing
`define OCST_CLK_MHZ 200
`define OCST_TICK_US 1000
`define OCST_REL_STEP_MS 15'h0005

// register map, byte addresses
`define OCST_STAGE_STRIDE 8'h10
`define OCST_CFG_OFS 4'h0
`define OCST_ISET_OFS 4'h4
`define OCST_DIAL_OFS 4'h8
`define OCST_STAT_OFS 4'hC
`define OCST_GEN_OFS 8'h40
`define OCST_IRQ_STAT_OFS 8'h44
`define OCST_IRQ_CLR_OFS 8'h48
`define OCST_IRQ_EN_OFS 8'h4C

// stage config fields
`define OCST_MAG_LSB 0
`define OCST_CURVE_BIT 2
`define OCST_DLYREL_BIT 3
`define OCST_RSTAFT_BIT 4
`define OCST_CONT_BIT 5
`define OCST_FORCE_LSB 6
`define OCST_REL_LSB 16

// reset values
`define OCST_CFG_RESET 32'h000C0018
`define OCST_ISET_RESET 16'h0078
`define OCST_DIAL_RESET 16'h0064

// curve and pick-up constants
`define OCST_MG_A 10'h153
`define OCST_MG_B 10'h0EC
`define OCST_MG_SCALE 14'h2710
`define OCST_LG_BASE_MS 26'h00016A8
`define OCST_LG_SLOPE 11'h3A8
`define OCST_PCT_FULL 7'h64
`define OCST_PCT_RESET 7'h61

`endif

// file: src/ocst_pkg.sv
package ocst_pkg;

  typedef enum logic [1:0] {
    OCST_MAG_FUND,
    OCST_MAG_TRUE_RMS_MAGNITUDE,
    OCST_MAG_P2P,
    OCST_MAG_SPARE
  } ocst_mag_type;

  typedef enum logic [1:0] {
    OCST_FORCE_NORMAL,
    OCST_FORCE_START,
    OCST_FORCE_TRIP,
    OCST_FORCE_BLOCKED
  } ocst_force_type;

  typedef enum logic [1:0] {
    OCST_IDLE,
    OCST_ACTIVE,
    OCST_RELEASE
  } ocst_phase_type;

  typedef logic [15:0] ocst_mag_word_type;

endpackage : ocst_pkg

// file: src/ocst_top.sv
`timescale 1ns/1ps
`include "ocst_defines.svh"

// Contract
// - mechanical curve delay equals dial over linear term
// - log curve delay from natural log ratio
// - negative log curve delay trips instantly
// - no trip during release without new pick-up
// - start held for release time, else clears
// - release time in 5 ms steps, default 60 ms
// - counter clears after full release, else at drop
// - continued calculation advances counter during release
// - no delayed release clears counter at drop
// - delayed release with reset-after freezes counter value
// - forcing sets normal, start, trip or blocked
// - measured currents still act under start forcing
// - four independent stages from phase magnitudes
// - per-phase pick-up, any phase count
// - magnitude select fundamental, true rms, peak-to-peak
// - pick above threshold, release below 97 percent
module ocst_top
  import ocst_pkg::*;
#(
  parameter int TICK_CYCLES = `OCST_TICK_US * `OCST_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] phase_a_fundamental_i,
  input wire logic [15:0] phase_b_fundamental_i,
  input wire logic [15:0] phase_c_fundamental_i,
  input wire logic [15:0] phase_a_true_rms_i,
  input wire logic [15:0] phase_b_true_rms_i,
  input wire logic [15:0] phase_c_true_rms_i,
  input wire logic [15:0] phase_a_peak_to_peak_i,
  input wire logic [15:0] phase_b_peak_to_peak_i,
  input wire logic [15:0] phase_c_peak_to_peak_i,
  output logic [3:0] start_o,
  output logic [3:0] trip_o,
  output logic [11:0] phase_start_o,
  output logic irq_o
);

  function automatic logic [31:0] ocst_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    ocst_merge = (old & ~m) | (dat & m);
  endfunction : ocst_merge

  // log2 in 5.8 fixed point, mantissa taken as linear: error below 0.09 octave
  function automatic logic [12:0] ocst_log2q(input logic [31:0] x);
    logic [4:0] pos;
    logic [31:0] norm;
    pos = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        pos = 5'(i);
      end
    end
    norm = x << (5'h1F - pos);
    ocst_log2q = {pos, norm[30:23]};
  endfunction : ocst_log2q

  ocst_mag_word_type mag_fund [0:2];
  ocst_mag_word_type mag_true_rms_magnitude [0:2];
  ocst_mag_word_type mag_pp [0:2];

  assign mag_fund[0] = phase_a_fundamental_i;
  assign mag_fund[1] = phase_b_fundamental_i;
  assign mag_fund[2] = phase_c_fundamental_i;
  assign mag_true_rms_magnitude[0] = phase_a_true_rms_i;
  assign mag_true_rms_magnitude[1] = phase_b_true_rms_i;
  assign mag_true_rms_magnitude[2] = phase_c_true_rms_i;
  assign mag_pp[0] = phase_a_peak_to_peak_i;
  assign mag_pp[1] = phase_b_peak_to_peak_i;
  assign mag_pp[2] = phase_c_peak_to_peak_i;

  // bus access
  wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_en = access & wb_we_i;
  wire [3:0] adr_stage = wb_adr_i[7:4];
  wire [3:0] adr_word = wb_adr_i[3:0];
  wire wr_gen = wr_en && (wb_adr_i == `OCST_GEN_OFS);
  wire wr_clr = wr_en && (wb_adr_i == `OCST_IRQ_CLR_OFS);
  wire wr_ien = wr_en && (wb_adr_i == `OCST_IRQ_EN_OFS);

  logic force_en;
  logic [7:0] irq_stat;
  logic [7:0] irq_en;
  logic [31:0] rd_data;

  // millisecond tick; the divider is a parameter so a bench can shorten it
  logic [17:0] tick_cnt;
  logic tick;
  wire tick_wrap = (tick_cnt == 18'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 18'h00000;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? 18'h00000 : tick_cnt + 18'h00001;
      tick <= tick_wrap;
    end
  end

  wire [31:0] cfg_w [0:3];
  wire [15:0] iset_w [0:3];
  wire [15:0] dial_w [0:3];
  wire [31:0] stat_w [0:3];
  wire [3:0] start_w;
  wire [3:0] trip_w;
  wire [11:0] phase_w;

  for (genvar s = 0; s < 4; s++) begin : g_stage
    localparam logic [7:0] BASE = 8'(s) * `OCST_STAGE_STRIDE;
    logic [31:0] cfg;
    logic [15:0] iset;
    logic [15:0] dial;
    logic [2:0] ph_pick;
    wire [2:0] next_ph_pick;
    wire [15:0] sel_mag [0:2];
    wire stage_hit = wr_en && (adr_stage == BASE[7:4]);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg <= `OCST_CFG_RESET;
        iset <= `OCST_ISET_RESET;
        dial <= `OCST_DIAL_RESET;
      end else if (stage_hit) begin
        if (adr_word == `OCST_CFG_OFS) begin
          cfg <= ocst_merge(cfg, wb_dat_i, wb_sel_i);
        end else if (adr_word == `OCST_ISET_OFS) begin
          iset <= 16'(ocst_merge({16'h0000, iset}, wb_dat_i, wb_sel_i));
        end else if (adr_word == `OCST_DIAL_OFS) begin
          dial <= 16'(ocst_merge({16'h0000, dial}, wb_dat_i, wb_sel_i));
        end
      end
    end

    wire ocst_mag_type msel = ocst_mag_type'(cfg[`OCST_MAG_LSB +: 2]);
    wire curve_log = cfg[`OCST_CURVE_BIT];
    wire dly_rel = cfg[`OCST_DLYREL_BIT];
    wire rst_after = cfg[`OCST_RSTAFT_BIT];
    wire cont = cfg[`OCST_CONT_BIT];
    wire ocst_force_type fsel = ocst_force_type'(cfg[`OCST_FORCE_LSB +: 2]);
    wire [14:0] rel_steps = cfg[`OCST_REL_LSB +: 15];
    wire [19:0] rel_limit = 20'(rel_steps * `OCST_REL_STEP_MS);

    for (genvar p = 0; p < 3; p++) begin : g_phase
      wire [15:0] mag = (msel == OCST_MAG_TRUE_RMS_MAGNITUDE) ? mag_true_rms_magnitude[p] :
                        (msel == OCST_MAG_P2P) ? mag_pp[p] : mag_fund[p];
      wire [22:0] mag_pct = 23'(mag * `OCST_PCT_FULL);
      wire [22:0] rel_pct = 23'(iset * `OCST_PCT_RESET);
      assign sel_mag[p] = mag;
      assign next_ph_pick[p] = (mag > iset) ? 1'b1 :
                               (mag_pct < rel_pct) ? 1'b0 : ph_pick[p];
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ph_pick <= 3'h0;
      end else begin
        ph_pick <= next_ph_pick;
      end
    end

    wire pick = |ph_pick;
    wire [15:0] max_ab = (sel_mag[0] > sel_mag[1]) ? sel_mag[0] : sel_mag[1];
    wire [15:0] im = (max_ab > sel_mag[2]) ? max_ab : sel_mag[2];

    logic [19:0] op_cnt;
    logic [19:0] rel_cnt;
    ocst_phase_type st;

    // mechanical grading without a divider: cnt*(A*im - B*iset) >= dial*im*scale
    wire signed [26:0] mg_num = $signed({2'b00, 25'(im * `OCST_MG_A)}) -
                                $signed({2'b00, 25'(iset * `OCST_MG_B)});
    wire [47:0] mg_lhs = 48'(op_cnt) * 48'(mg_num[24:0]);
    wire [47:0] mg_rhs = 48'(dial) * 48'(im) * 48'(`OCST_MG_SCALE);
    wire mg_reached = (mg_num > 27'sh0) && (mg_lhs >= mg_rhs);

    // log curve: ln via log2; the slope carries 1.35*ln2 in milliseconds
    wire [12:0] lg_num = ocst_log2q(32'(im * `OCST_PCT_FULL));
    wire [12:0] lg_den = ocst_log2q(32'(dial) * 32'(iset));
    wire signed [13:0] lg_diff = $signed({1'b0, lg_num}) - $signed({1'b0, lg_den});
    wire signed [25:0] lg_prod = 26'(lg_diff * $signed({1'b0, `OCST_LG_SLOPE}));
    wire signed [25:0] lg_delay = $signed(`OCST_LG_BASE_MS) - (lg_prod >>> 8);
    wire [25:0] lg_clamp = lg_delay[25] ? 26'h0000000 : lg_delay;
    wire lg_reached = ({6'h00, op_cnt} >= lg_clamp);

    wire reached = curve_log ? lg_reached : mg_reached;
    wire rel_done = (rel_cnt + 20'h00001 >= rel_limit);
    wire [19:0] op_inc = (op_cnt == 20'hFFFFF) ? op_cnt : op_cnt + 20'h00001;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st <= OCST_IDLE;
        op_cnt <= 20'h00000;
        rel_cnt <= 20'h00000;
      end else begin
        case (st)
          OCST_IDLE: begin
            if (pick) begin
              st <= OCST_ACTIVE;
            end
          end
          OCST_ACTIVE: begin
            if (!pick) begin
              rel_cnt <= 20'h00000;
              if (!dly_rel) begin
                st <= OCST_IDLE;
                op_cnt <= 20'h00000;
              end else begin
                st <= OCST_RELEASE;
                if (!rst_after && !cont) begin
                  op_cnt <= 20'h00000;
                end
              end
            end else if (tick) begin
              op_cnt <= op_inc;
            end
          end
          OCST_RELEASE: begin
            if (pick) begin
              st <= OCST_ACTIVE;
            end else if (tick) begin
              if (rel_done) begin
                st <= OCST_IDLE;
                op_cnt <= 20'h00000;
              end else begin
                rel_cnt <= rel_cnt + 20'h00001;
                if (cont) begin
                  op_cnt <= op_inc;
                end
                // otherwise op_cnt holds its value
              end
            end
          end
          default: begin
            st <= OCST_IDLE;
          end
        endcase
      end
    end

    wire start_raw = (st != OCST_IDLE);
    // trip needs live pick-up, so a counter run on during release cannot trip
    wire trip_raw = pick && (st == OCST_ACTIVE) && reached;
    wire forced = force_en && (fsel != OCST_FORCE_NORMAL);
    wire blocked = forced && (fsel == OCST_FORCE_BLOCKED);
    // real measurements keep acting under start forcing
    assign start_w[s] = blocked ? 1'b0 : (forced ? 1'b1 : start_raw);
    assign trip_w[s] = blocked ? 1'b0 :
                       (forced && (fsel == OCST_FORCE_TRIP)) ? 1'b1 : trip_raw;
    assign phase_w[3*s +: 3] = blocked ? 3'h0 : (forced ? 3'h7 : (ph_pick & {3{start_raw}}));

    assign cfg_w[s] = cfg;
    assign iset_w[s] = iset;
    assign dial_w[s] = dial;
    assign stat_w[s] = {op_cnt, 6'h00, ph_pick, pick, trip_o[s], start_o[s]};
  end

  // interrupt events: rising start and trip of each stage
  wire [7:0] irq_event = {trip_w & ~trip_o, start_w & ~start_o};
  wire [7:0] clr_mask = wr_clr ? 8'(ocst_merge(32'h00000000, wb_dat_i, wb_sel_i)) : 8'h00;
  // a clear in the same cycle as an event loses to the event
  wire [7:0] next_irq_stat = (irq_stat & ~clr_mask) | irq_event;

  // forcing stays off after reset so a test setting cannot outlive a restart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_en <= 1'b0;
    end else if (wr_gen && wb_sel_i[0]) begin
      force_en <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= 8'h00;
    end else if (wr_ien && wb_sel_i[0]) begin
      irq_en <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 8'h00;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // one cycle behind the status, traded for an output straight from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_en);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_o <= 4'h0;
    end else begin
      start_o <= start_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_o <= 4'h0;
    end else begin
      trip_o <= trip_w;
    end
  end

  // phase bits are gated by the stage start, so a released stage shows none
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_start_o <= 12'h000;
    end else begin
      phase_start_o <= phase_w;
    end
  end

  // read decode; unmapped and unaligned addresses read zero but still ack
  always_comb begin
    rd_data = 32'h00000000;
    if (adr_stage < 4'h4) begin
      if (adr_word == `OCST_CFG_OFS) begin
        rd_data = cfg_w[adr_stage[1:0]];
      end else if (adr_word == `OCST_ISET_OFS) begin
        rd_data = {16'h0000, iset_w[adr_stage[1:0]]};
      end else if (adr_word == `OCST_DIAL_OFS) begin
        rd_data = {16'h0000, dial_w[adr_stage[1:0]]};
      end else if (adr_word == `OCST_STAT_OFS) begin
        rd_data = stat_w[adr_stage[1:0]];
      end
    end else if (wb_adr_i == `OCST_GEN_OFS) begin
      rd_data = {31'h00000000, force_en};
    end else if (wb_adr_i == `OCST_IRQ_STAT_OFS) begin
      rd_data = {24'h000000, irq_stat};
    end else if (wb_adr_i == `OCST_IRQ_EN_OFS) begin
      rd_data = {24'h000000, irq_en};
    end
  end

  // ack blocks a second access in its own cycle, so a held strobe acks every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= (access && !wb_we_i) ? rd_data : 32'h00000000;
    end
  end

endmodule : ocst_top

// file: verification/ocst_monitor.sv
`timescale 1ns/1ps
module ocst_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] start_o,
  input wire logic [3:0] trip_o,
  input wire logic [11:0] phase_start_o,
  input wire logic irq_o
);
  wire [3:0] ph_any = {|phase_start_o[11:9], |phase_start_o[8:6], |phase_start_o[5:3],
    |phase_start_o[2:0]};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  ack_pulse_a: assert property (req_s |=> ack_s)
    else $error("ack is not a single pulse");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  trip_start_a: assert property ((trip_o & ~start_o) == 4'h0)
    else $error("trip without start");
  phase_start_a: assert property ((ph_any & ~start_o) == 4'h0)
    else $error("phase start without stage start");
  reset_quiet_a: assert property ($fell(rst_i) |-> (start_o | trip_o) == 4'h0 && !irq_o)
    else $error("outputs active after reset");
  // irq may only fall after a clear or enable write, since status is sticky
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_we_i && wb_stb_i)
    || $past(wb_we_i && wb_stb_i, 2)) else $error("irq fell without a write");
  irq_rise_a: assert property ($rose(irq_o) |-> start_o != 4'h0
    || $past(wb_we_i && wb_stb_i) || $past(wb_we_i && wb_stb_i, 2))
    else $error("irq rose without cause");
endmodule : ocst_monitor

bind ocst_top ocst_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .start_o(start_o), .trip_o(trip_o), .phase_start_o(phase_start_o), .irq_o(irq_o));

// file: verification/ocst_meas_model.sv
`timescale 1ns/1ps
module ocst_meas_model
  import ocst_pkg::*;
(
  input wire logic clk_i,
  input wire ocst_mag_type kind_i,
  input wire logic [47:0] lvl_i,
  output logic [47:0] fund_o,
  output logic [47:0] true_rms_magnitude_o,
  output logic [47:0] pp_o
);
  // unused kinds carry the complement, so reading the wrong kind shows as a pick-up
  always_ff @(posedge clk_i) begin
    fund_o <= (kind_i == OCST_MAG_FUND || kind_i == OCST_MAG_SPARE) ? lvl_i : ~lvl_i;
    true_rms_magnitude_o <= (kind_i == OCST_MAG_TRUE_RMS_MAGNITUDE) ? lvl_i : ~lvl_i;
    pp_o <= (kind_i == OCST_MAG_P2P) ? lvl_i : ~lvl_i;
  end
endmodule : ocst_meas_model

// file: verification/ocst_tb_top.sv
`timescale 1ns/1ps
module ocst_tb_top
  import ocst_pkg::*;
;
  localparam int TK = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, trp = 1'b0;
  logic ack, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [3:0] start, trip;
  logic [11:0] phs;
  logic [47:0] lvl = 48'h0, fund, true_rms_magnitude, pp;
  ocst_mag_type kind = OCST_MAG_FUND;
  int fail_count = 0, comparisons = 0, c0, d;
  ocst_top #(.TICK_CYCLES(TK)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .phase_a_fundamental_i(fund[15:0]),
    .phase_b_fundamental_i(fund[31:16]), .phase_c_fundamental_i(fund[47:32]),
    .phase_a_true_rms_i(true_rms_magnitude[15:0]), .phase_b_true_rms_i(true_rms_magnitude[31:16]),
    .phase_c_true_rms_i(true_rms_magnitude[47:32]), .phase_a_peak_to_peak_i(pp[15:0]),
    .phase_b_peak_to_peak_i(pp[31:16]), .phase_c_peak_to_peak_i(pp[47:32]),
    .start_o(start), .trip_o(trip), .phase_start_o(phs), .irq_o(irq));
  ocst_meas_model mdl (.clk_i(clk_i), .kind_i(kind), .lvl_i(lvl), .fund_o(fund),
    .true_rms_magnitude_o(true_rms_magnitude), .pp_o(pp));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (trip[0] === 1'b1) trp <= 1'b1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    repeat (20) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) fail_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    bus(1'b1, a, dt);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk
  task automatic ms(input int n);
    repeat (n * TK) @(posedge clk_i);
  endtask : ms
  function automatic int mech_ms(input int k, input int im);
    longint n = longint'(k) * im * 10000;
    longint q = 339 * im - 236 * 120;
    return int'((n + q - 1) / q);
  endfunction : mech_ms
  function automatic int log_ms(input int k, input int im);
    real t = 5800.0 - 1350.0 * $ln(100.0 * im / (k * 120.0));
    return t < 0.0 ? 0 : int'(t);
  endfunction : log_ms
  // phase b sits above the threshold but below phase c, so only the maximum sets the delay
  task automatic trip_run(input logic [31:0] cfg, input int im, input int ems, input int tol);
    wr(8'h00, cfg);
    lvl <= {16'(im), 16'h0082, 16'h0000};
    if (ems > tol) begin
      ms(ems - tol);
      check(trip[0], 1'b0);
    end
    ms(2 * tol);
    check(trip[0], 1'b1);
    lvl <= 48'h0;
    ms(80);
    $display("trip run done");
  endtask : trip_run
  task automatic test_done;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'h7948));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 64; s += 16) begin
      rchk(8'(s), 32'h000C0018);
      rchk(8'(s + 4), 32'h78);
      rchk(8'(s + 8), 32'h64);
    end
    wr(8'h0C, 32'hFFFFFFFF);
    rchk(8'h0C, 32'h0);
    rchk(8'h4C, 32'h0);
    rchk(8'h52, 32'h0);
    $display("registers done");
    wr(8'h14, 32'h200);
    lvl <= 48'h0000_0078_0000;
    ms(1);
    check(start, 4'h0);
    // stays below the raised threshold of stage 1
    lvl[31:16] <= 16'(121 + $urandom_range(0, 390));
    repeat (6) @(posedge clk_i);
    check(start, 4'hD);
    check(phs, 12'h482);
    check(irq, 1'b0);
    rchk(8'h44, 32'hD);
    wr(8'h4C, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b1);
    wr(8'h48, 32'hFF);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0);
    lvl[31:16] <= 16'd117;
    ms(1);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[2], 1'b1);
    lvl[31:16] <= 16'd116;
    ms(1);
    bus(1'b0, 8'h0C, 32'h0);
    check({rd[2], start[0]}, 2'b01);
    ms(70);
    check(start, 4'h0);
    $display("pick-up done");
    wr(8'h08, 32'd10);
    c0 = 200 + $urandom_range(0, 300);
    trip_run(32'h000C0018, c0, mech_ms(10, c0), 2);
    // the coarse hardware logarithm may run about 30 ms early at this point
    trip_run(32'h000C001C, 700, log_ms(10, 700), 40);
    trip_run(32'h000C001C, 2000, log_ms(10, 2000), 1);
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, m == 0 ? 32'h00040010 : m == 1 ? 32'h00040018 : 32'h00040038);
      trp <= 1'b0;
      lvl <= 48'h00F0;
      ms(445);
      lvl <= 48'h0;
      ms(1);
      bus(1'b0, 8'h0C, 32'h0);
      c0 = rd[31:12];
      check(m == 0 ? c0 == 0 : c0 > 442 && c0 < 448, 1'b1);
      ms(10);
      bus(1'b0, 8'h0C, 32'h0);
      d = rd[31:12] - c0;
      check(m == 2 ? d > 8 && d < 13 : d == 0, 1'b1);
      ms(7);
      check(start[0], m != 0);
      ms(4);
      bus(1'b0, 8'h0C, 32'h0);
      check({rd[31:12], start[0], trp}, 22'h0);
    end
    $display("release done");
    wr(8'h40, 32'h1);
    lvl <= 48'h00F0;
    for (int f = 0; f < 4; f++) begin
      wr(8'h20, 32'h000C0018 | (f << 6));
      ms(1);
      check({start[2], trip[2]}, f == 3 ? 2'b00 : f == 2 ? 2'b11 : 2'b10);
    end
    wr(8'h40, 32'h0);
    $display("forcing done");
    for (int k = 0; k < 4; k++) begin
      kind <= ocst_mag_type'(k);
      lvl <= 48'h0;
      wr(8'h00, 32'h000C0018 | k);
      ms(70);
      lvl <= {3{16'h0064}};
      ms(1);
      check(start[0], 1'b0);
      lvl <= {16'h00F0, 32'h0};
      ms(1);
      check(start[0], 1'b1);
    end
    $display("magnitude done");
    test_done();
  end
endmodule : ocst_tb_top
